//--- rtl/rtc_map.svh
// Offsets, field positions, reset values and timing counts of the RTC regs
// How it works
// - Write protect set blocks every register write, control enables too.
// - With protect set, a control write may only clear protect.
// - One-hertz pin driven when its enable is 1, else high impedance.
// - Alarm 0 pin low only while alarm 0 flag and its enable are 1.
// - Alarm 1 enable at 0 keeps the alarm 1 pin at logic 0.
// - Control read at 0Fh, written at 8Fh; bits 7,5,4,3 read 0.
// - Alarm 0 match sets alarm 0 flag; with enable, pin goes low.
// - Pointer at any alarm 0 register, read or write, clears alarm 0 flag.
// - Alarm 1 flag set with enable gives one 62.5 ms high pulse.
// - Pointer at any alarm 1 register, read or write, clears alarm 1 flag.
// - Alarm 0 flag sets on any supply; alarm 1 only on secondary/battery.
// - Status read-only at 10h: alarm 1 flag bit 1, alarm 0 bit 0.
// - Charger enabled only when the unlock field holds 1010.
// - Diode field 01 one diode, 10 two; 00 and 11 disable charger.
// - Resistor field 01/10/11 selects 2k/4k/8k; 00 disables charger.
// - Charger register powers up as 0101, 11, 00: charger disabled.
// - Battery-backup configuration refuses all writes while on battery.
// - Dual-supply switching never imposes write protection by itself.
// - Alarm 0 at 87h-8Ah, alarm 1 at 8Bh-8Eh; these clear the flags.
// - Each clock update compares both alarm groups with current time.
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

`define RTC_CTRL_RD 8'h0F
`define RTC_CTRL_WR 8'h8F
`define RTC_STAT_RD 8'h10
`define RTC_STAT_WR 8'h90
`define RTC_CHG_RD 8'h11
`define RTC_CHG_WR 8'h91
`define RTC_AL0_RD_LO 8'h07
`define RTC_AL0_RD_HI 8'h0A
`define RTC_AL1_RD_LO 8'h0B
`define RTC_AL1_RD_HI 8'h0E
`define RTC_AL0_WR_LO 8'h87
`define RTC_AL0_WR_HI 8'h8A
`define RTC_AL1_WR_LO 8'h8B
`define RTC_AL1_WR_HI 8'h8E

`define RTC_CTRL_WP_BIT 6
`define RTC_CTRL_HZ_BIT 2
`define RTC_CTRL_ALARM1_IRQ_ENABLE_BIT 1
`define RTC_CTRL_ALARM0_IRQ_ENABLE_BIT 0
`define RTC_STAT_F1_BIT 1
`define RTC_STAT_F0_BIT 0

`define RTC_CTRL_RESET 8'h40
`define RTC_CHG_RESET 8'h5C
`define RTC_CHG_UNLOCK 4'hA

`define RTC_PULSE_US 62500
`define RTC_CLK_NS 100
`define RTC_PULSE_CYC ((`RTC_PULSE_US * 1000) / `RTC_CLK_NS)

`endif

//--- rtl/rtc_pkg.sv
// Types shared by the RTC special register block
package rtc_pkg;

   // Active supply source from the power switch
   typedef enum logic [1:0] {
      RTC_SUP_PRIMARY = 2'h0,
      RTC_SUP_SECONDARY = 2'h1,
      RTC_SUP_BATTERY = 2'h2
   } rtc_supply_t;

   // Access from the serial shifter, same clock domain
   typedef struct packed {
      logic ptr_move;
      logic wr_strobe;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rtc_acc_t;

   // Stored control bits
   typedef struct packed {
      logic wp;
      logic one_hertz_out_enable;
      logic alarm1_irq_enable;
      logic alarm0_irq_enable;
   } rtc_ctrl_t;

   // Stored charger register fields
   typedef struct packed {
      logic [3:0] charger_unlock_field;
      logic [1:0] diode_count_select;
      logic [1:0] resistor_select;
   } rtc_chg_t;

   // Drive to the analog charger switches
   typedef struct packed {
      logic enable;
      logic two_diodes;
      logic [1:0] resistor_select;
   } rtc_chg_drive_t;

   // Pulse timer states
   typedef enum logic [1:0] {
      RTC_P_IDLE = 2'h1,
      RTC_P_HIGH = 2'h2
   } rtc_pulse_state_t;

endpackage

//--- rtl/rtc_pulse.sv
// Fixed-length active-high pulse timer for the alarm 1 pin
`timescale 1ns/1ns
`default_nettype none
module rtc_pulse #(
   parameter int unsigned LEN = 625000 // Pulse length in cycles
) (
   input wire logic core_clk, // Core clock
   input wire logic rst_b, // Async reset, active low
   input wire logic start, // Start a pulse
   input wire logic kill, // Force the output low
   output logic pulse // Registered pulse output
);
   rtc_pkg::rtc_pulse_state_t state;
   logic [19:0] count;

   // Pulse state and length counter; a new start during a pulse is merged
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= rtc_pkg::RTC_P_IDLE;
         count <= 20'h00000;
         pulse <= 1'b0;
      end else begin
         case (state)
            rtc_pkg::RTC_P_IDLE: begin
               if (start && !kill) begin
                  state <= rtc_pkg::RTC_P_HIGH;
                  count <= 20'(LEN - 1);
                  pulse <= 1'b1;
               end
            end
            rtc_pkg::RTC_P_HIGH: begin
               if (kill || count == 20'h00000) begin
                  state <= rtc_pkg::RTC_P_IDLE;
                  pulse <= 1'b0;
               end else begin
                  count <= count - 20'h00001;
               end
            end
            default: begin
               state <= rtc_pkg::RTC_P_IDLE;
               pulse <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- rtl/rtc_regs.sv
// RTC control, alarm status and charger registers with write gating
`timescale 1ns/1ns
`default_nettype none
`include "rtc_map.svh"
module rtc_regs #(
   parameter int unsigned PULSE_CYC = `RTC_PULSE_CYC // Alarm 1 pulse
) (
   input wire logic core_clk, // Core clock, 10 MHz
   input wire logic rst_b, // Async reset, active low
   input wire rtc_pkg::rtc_acc_t acc, // Access from serial shifter
   input wire logic alarm0_match, // Alarm 0 match at clock update
   input wire logic alarm1_match, // Alarm 1 match at clock update
   input wire logic [1:0] supply_pin, // Active supply, async
   input wire logic batt_cfg_pin, // Battery-backup configuration strap
   input wire logic one_hz_src, // 1 Hz square wave, async
   output logic [7:0] rd_data, // Read data for the shifter
   output logic write_allow, // Clock and RAM writes allowed
   output logic wr_refused, // Pulse: a write was refused
   output logic alarm0_irq_n, // Alarm 0 interrupt, active low
   output logic alarm1_irq_pulse, // Alarm 1 interrupt pulse
   output logic one_hz_out, // 1 Hz pin output value
   output logic one_hz_oe, // 1 Hz pin output enable
   output rtc_pkg::rtc_chg_drive_t chg_drive // Charger switch drive
);
   localparam int SYNC_W = 4;

   logic [SYNC_W-1:0] sync_in;
   logic [SYNC_W-1:0] sync_meta;
   logic [SYNC_W-1:0] sync_q;
   rtc_pkg::rtc_supply_t supply;
   logic batt_cfg;
   logic hz_src;
   rtc_pkg::rtc_ctrl_t ctrl;
   rtc_pkg::rtc_chg_t chg;
   logic alarm0_flag;
   logic alarm1_flag;
   logic on_battery_lock;
   logic wr_gate;
   logic wr_ctrl;
   logic wr_chg;
   logic touch_al0;
   logic touch_al1;
   logic set_f1;
   logic next_f1;
   logic pulse_start;

   assign sync_in = {one_hz_src, batt_cfg_pin, supply_pin};

   // Two-flop synchronisers for every pin input
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               sync_meta[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
            end else begin
               sync_meta[gi] <= sync_in[gi];
               sync_q[gi] <= sync_meta[gi];
            end
         end
      end
   endgenerate

   assign supply = rtc_pkg::rtc_supply_t'(sync_q[1:0]);
   assign batt_cfg = sync_q[2];
   assign hz_src = sync_q[3];

   // Only the battery-backup configuration locks on battery; the
   // dual-supply setup switches freely without locking
   assign on_battery_lock = batt_cfg &&
      (supply == rtc_pkg::RTC_SUP_BATTERY);

   // Writes other than to control need protect clear and no battery lock
   assign wr_gate = !ctrl.wp && !on_battery_lock;

   assign wr_ctrl = acc.wr_strobe && acc.addr == `RTC_CTRL_WR;
   assign wr_chg = acc.wr_strobe && acc.addr == `RTC_CHG_WR;

   // Pointer landing on any alarm register, read or write form
   assign touch_al0 = acc.ptr_move &&
      ((acc.addr >= `RTC_AL0_RD_LO && acc.addr <= `RTC_AL0_RD_HI) ||
       (acc.addr >= `RTC_AL0_WR_LO && acc.addr <= `RTC_AL0_WR_HI));
   assign touch_al1 = acc.ptr_move &&
      ((acc.addr >= `RTC_AL1_RD_LO && acc.addr <= `RTC_AL1_RD_HI) ||
       (acc.addr >= `RTC_AL1_WR_LO && acc.addr <= `RTC_AL1_WR_HI));

   // Control register; protect comes up set so the host must clear it
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl.wp <= 1'(`RTC_CTRL_RESET >> `RTC_CTRL_WP_BIT);
         ctrl.one_hertz_out_enable <= 1'b0;
         ctrl.alarm1_irq_enable <= 1'b0;
         ctrl.alarm0_irq_enable <= 1'b0;
      end else if (wr_ctrl && !on_battery_lock) begin
         if (ctrl.wp) begin
            // Protected: only the protect bit may change, and only down
            ctrl.wp <= acc.wdata[`RTC_CTRL_WP_BIT];
         end else begin
            ctrl.wp <= acc.wdata[`RTC_CTRL_WP_BIT];
            ctrl.one_hertz_out_enable <= acc.wdata[`RTC_CTRL_HZ_BIT];
            ctrl.alarm1_irq_enable <= acc.wdata[`RTC_CTRL_ALARM1_IRQ_ENABLE_BIT];
            ctrl.alarm0_irq_enable <= acc.wdata[`RTC_CTRL_ALARM0_IRQ_ENABLE_BIT];
         end
      end
   end

   // Charger register; reserved-free, all eight bits stored
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         chg <= `RTC_CHG_RESET;
      end else if (wr_chg && wr_gate) begin
         chg <= acc.wdata;
      end
   end

   // Charger drive: unlock, valid diode count and nonzero resistor
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         chg_drive <= '0;
      end else begin
         chg_drive.enable <=
            chg.charger_unlock_field == `RTC_CHG_UNLOCK &&
            (chg.diode_count_select == 2'h1 ||
             chg.diode_count_select == 2'h2) &&
            chg.resistor_select != 2'h0;
         chg_drive.two_diodes <= chg.diode_count_select == 2'h2;
         chg_drive.resistor_select <= chg.resistor_select;
      end
   end

   // Alarm 0 flag: set on match from any supply; set beats clear
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         alarm0_flag <= 1'b0;
      end else if (alarm0_match) begin
         alarm0_flag <= 1'b1;
      end else if (touch_al0) begin
         alarm0_flag <= 1'b0;
      end
   end

   // Alarm 1 only qualifies off the primary supply
   assign set_f1 = alarm1_match &&
      (supply == rtc_pkg::RTC_SUP_SECONDARY ||
       supply == rtc_pkg::RTC_SUP_BATTERY);

   always_comb begin
      next_f1 = alarm1_flag;
      if (touch_al1) begin
         next_f1 = 1'b0;
      end
      if (set_f1) begin
         next_f1 = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         alarm1_flag <= 1'b0;
      end else begin
         alarm1_flag <= next_f1;
      end
   end

   // A pulse starts on each rising of the flag while enabled
   assign pulse_start = next_f1 && !alarm1_flag &&
      ctrl.alarm1_irq_enable;

   rtc_pulse #(
      .LEN(PULSE_CYC)
   ) u_pulse (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .start(pulse_start),
      .kill(!ctrl.alarm1_irq_enable),
      .pulse(alarm1_irq_pulse)
   );

   // Alarm 0 pin is a level, low while flag and enable both hold
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         alarm0_irq_n <= 1'b1;
      end else begin
         alarm0_irq_n <= !(alarm0_flag && ctrl.alarm0_irq_enable);
      end
   end

   // 1 Hz pin; value follows the synced source, enable gates the driver
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         one_hz_out <= 1'b0;
         one_hz_oe <= 1'b0;
      end else begin
         one_hz_out <= hz_src;
         one_hz_oe <= ctrl.one_hertz_out_enable;
      end
   end

   // Read data captured when the pointer lands; unmapped reads give 0
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 8'h00;
      end else if (acc.ptr_move) begin
         case (acc.addr)
            `RTC_CTRL_RD: begin
               rd_data <= {1'b0, ctrl.wp, 3'h0, ctrl.one_hertz_out_enable,
                  ctrl.alarm1_irq_enable, ctrl.alarm0_irq_enable};
            end
            `RTC_STAT_RD: begin
               rd_data <= {6'h00, alarm1_flag, alarm0_flag};
            end
            `RTC_CHG_RD: begin
               rd_data <= chg;
            end
            default: begin
               rd_data <= 8'h00;
            end
         endcase
      end
   end

   // Gate for clock and RAM writes elsewhere; status writes are dropped
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         write_allow <= 1'b0;
         wr_refused <= 1'b0;
      end else begin
         write_allow <= wr_gate;
         wr_refused <= acc.wr_strobe && (!wr_gate ||
            acc.addr == `RTC_STAT_WR) &&
            !(wr_ctrl && !on_battery_lock);
      end
   end
endmodule
`default_nettype wire

//--- tb/rtc_regs_monitor.sv
// Checker for the RTC special register block
`timescale 1ns/1ns
`default_nettype none
module rtc_regs_monitor #(
   parameter int unsigned PULSE_CYC = 20 // Alarm 1 pulse
) (
   input wire logic core_clk, // Core clock
   input wire logic rst_b, // Reset, active low
   input wire rtc_pkg::rtc_acc_t acc, // Shifter access
   input wire logic alarm0_match, // Alarm 0 match
   input wire logic alarm1_match, // Alarm 1 match
   input wire logic [1:0] supply_pin, // Supply source
   input wire logic batt_cfg_pin, // Battery strap
   input wire logic write_allow, // Writes allowed
   input wire logic wr_refused, // Refused write
   input wire logic alarm0_irq_n, // Alarm 0 pin
   input wire logic alarm1_irq_pulse, // Alarm 1 pin
   input wire logic one_hz_oe, // 1 Hz enable
   input wire logic one_hz_src, // 1 Hz source pin
   input wire logic one_hz_out, // 1 Hz pin value
   input wire rtc_pkg::rtc_chg_drive_t chg_drive // Charger drive
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic [31:0] hi_cnt;
   logic ctl_wr;
   // Cycles the alarm 1 pulse has been high so far
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         hi_cnt <= 32'h0;
      else if (alarm1_irq_pulse)
         hi_cnt <= hi_cnt + 32'h1;
      else
         hi_cnt <= 32'h0;
   end
   // Accepted control write; lag of write_allow handled per property
   assign ctl_wr = write_allow && acc.wr_strobe && acc.addr == 8'h8F;
   a_lock_charger: assert property (!write_allow &&
      !$past(acc.wr_strobe) && acc.wr_strobe && acc.addr == 8'h91
      |=> ##1 $stable(chg_drive)) else $error("charger write leaked");
   a_hz_enable: assert property (ctl_wr && !$past(acc.wr_strobe)
      |=> ##2 one_hz_oe == $past(acc.wdata[2], 3))
      else $error("1 Hz enable does not follow control");
   a_alarm0_clear: assert property (acc.ptr_move &&
      acc.addr[6:0] inside {[7'h07:7'h0A]} && !alarm0_match
      && !$past(alarm0_match) |=> ##2 alarm0_irq_n)
      else $error("alarm 0 pin not released by pointer");
   a_pulse_max: assert property (alarm1_irq_pulse |->
      hi_cnt < PULSE_CYC) else $error("alarm 1 pulse too long");
   a_pulse_supply: assert property ($rose(alarm1_irq_pulse) |->
      $past(alarm1_match) && $past(supply_pin, 3) != 2'h0)
      else $error("alarm 1 pulse without qualified match");
   // Pin value lags the source by two sync flops and the output flop
   a_hz_follow: assert property (one_hz_out ==
      $past(one_hz_src, 3)) else $error("1 Hz pin does not follow source");
   a_pulse_off: assert property (ctl_wr && !acc.wdata[1] &&
      !$past(acc.wr_strobe) |=> ##2 !alarm1_irq_pulse [*4])
      else $error("alarm 1 pin high with enable off");
   a_status_ro: assert property (acc.wr_strobe &&
      acc.addr == 8'h90 |=> wr_refused)
      else $error("status write not refused");
   a_batt_lock: assert property ((batt_cfg_pin &&
      supply_pin == 2'h2) [*5] |-> !write_allow)
      else $error("writes allowed on battery");
   c_pulse: cover property ($fell(alarm1_irq_pulse));
   c_refused: cover property (wr_refused);
   c_alarm0: cover property (!alarm0_irq_n);
endmodule
bind rtc_regs rtc_regs_monitor #(.PULSE_CYC(PULSE_CYC)) rtc_regs_monitor_i (
   .core_clk(core_clk), .rst_b(rst_b), .acc(acc),
   .alarm0_match(alarm0_match), .alarm1_match(alarm1_match),
   .supply_pin(supply_pin), .batt_cfg_pin(batt_cfg_pin),
   .write_allow(write_allow), .wr_refused(wr_refused),
   .alarm0_irq_n(alarm0_irq_n), .alarm1_irq_pulse(alarm1_irq_pulse),
   .one_hz_oe(one_hz_oe), .one_hz_src(one_hz_src),
   .one_hz_out(one_hz_out), .chg_drive(chg_drive));
`default_nettype wire

//--- tb/rtc_host.sv
// Serial bus master model driving the register access port
`timescale 1ns/1ns
`default_nettype none
module rtc_host (
   input wire logic core_clk, // Core clock
   input wire logic [7:0] rd_data, // Read data back
   output var rtc_pkg::rtc_acc_t acc // Access to the block
);
   initial acc = '0;
   // One request cycle; released lines show the inverse, not old data
   task automatic cyc(input logic pm, ws, input logic [7:0] a, d);
      @(negedge core_clk);
      acc <= {pm, ws, a, d};
      @(negedge core_clk);
      acc <= {1'b0, 1'b0, ~a, ~d};
   endtask
   // Pointer lands on an address, byte taken once settled
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      cyc(1'b1, 1'b0, a, 8'h00);
      @(negedge core_clk);
      d = rd_data;
   endtask
   // Pointer on the write form, then a whole byte
   task automatic wr(input logic [7:0] a, d);
      cyc(1'b1, 1'b0, a, 8'h00);
      cyc(1'b0, 1'b1, a, d);
   endtask
   // Protect cleared before any other write
   task automatic unlock;
      wr(8'h8F, 8'h00);
   endtask
endmodule
`default_nettype wire

//--- tb/rtc_regs_tb.sv
// Self-checking bench for the RTC special register block
`timescale 1ns/1ns
`default_nettype none
module rtc_regs_tb;
   localparam int unsigned PCYC = 20;
   logic core_clk, rst_b, a0m, a1m, batt, hz_src, wa, wref;
   logic irq0_n, irq1, hz_o, hz_oe;
   logic [1:0] sup;
   logic [7:0] rdd, v;
   rtc_pkg::rtc_acc_t acc;
   rtc_pkg::rtc_chg_drive_t chg;
   int n_mismatch = 0;
   int cmp_count = 0;
   rtc_regs #(.PULSE_CYC(PCYC)) rtc_regs_i (.core_clk(core_clk),
      .rst_b(rst_b), .acc(acc), .alarm0_match(a0m), .alarm1_match(a1m),
      .supply_pin(sup), .batt_cfg_pin(batt), .one_hz_src(hz_src),
      .rd_data(rdd), .write_allow(wa), .wr_refused(wref),
      .alarm0_irq_n(irq0_n), .alarm1_irq_pulse(irq1), .one_hz_out(hz_o),
      .one_hz_oe(hz_oe), .chg_drive(chg));
   rtc_host rtc_host_i (.core_clk(core_clk), .rd_data(rdd), .acc(acc));
   // Core clock and the unrelated 1 Hz source stand-in
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      hz_src = 1'b0;
      #137;
      forever #400 hz_src = ~hz_src;
   end
   task automatic chk(input string nm, input logic [7:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, exp);
      logic [7:0] d;
      rtc_host_i.rd(a, d);
      chk(nm, d, exp);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // One match pulse on the chosen alarm
   task automatic hit(input logic sel);
      @(negedge core_clk);
      {a1m, a0m} = sel ? 2'b10 : 2'b01;
      @(negedge core_clk);
      {a1m, a0m} = 2'b00;
      ticks(3);
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic t_reset;
      rchk("ctrl", 8'h0F, 8'h40);
      rchk("chg", 8'h11, 8'h5C);
      chk("chg_en", chg.enable, 1'b0);
      rchk("status", 8'h10, 8'h00);
      $display("t_reset done");
   endtask
   task automatic t_protect;
      rtc_host_i.wr(8'h91, 8'hA5);
      rchk("chg_locked", 8'h11, 8'h5C);
      rtc_host_i.wr(8'h8F, 8'h47);
      rchk("ctrl_locked", 8'h0F, 8'h40);
      rtc_host_i.unlock();
      rchk("ctrl_clear", 8'h0F, 8'h00);
      rtc_host_i.wr(8'h8F, 8'hFF);
      rchk("ctrl_zeros", 8'h0F, 8'h47);
      chk("hz_oe_on", hz_oe, 1'b1);
      rtc_host_i.wr(8'h8F, 8'h00);
      rchk("ctrl_wp_only", 8'h0F, 8'h07);
      rtc_host_i.wr(8'h8F, 8'h00);
      ticks(2);
      chk("hz_oe_off", hz_oe, 1'b0);
      rtc_host_i.wr(8'h90, 8'hFF);
      chk("wref_status", wref, 1'b1);
      rchk("status_ro", 8'h10, 8'h00);
      $display("t_protect done");
   endtask
   task automatic t_charger;
      logic [7:0] tv [11];
      logic en;
      tv = '{8'hA5, 8'hA6, 8'hA7, 8'hA9, 8'hAA, 8'hAB, 8'hA4, 8'hA0,
         8'hAC, 8'hAD, 8'hB5};
      foreach (tv[i]) begin
         rtc_host_i.wr(8'h91, tv[i]);
         rchk("chg_rd", 8'h11, tv[i]);
         en = tv[i][7:4] == 4'hA && tv[i][3] != tv[i][2] && tv[i][1:0] != 0;
         chk("chg_en", chg.enable, en);
         if (en) begin
            chk("chg_diodes", chg.two_diodes, tv[i][3]);
            chk("chg_res", chg.resistor_select, tv[i][1:0]);
         end
      end
      $display("t_charger done");
   endtask
   task automatic t_alarm0;
      rtc_host_i.wr(8'h8F, 8'h01);
      hit(1'b0);
      chk("irq0_low", irq0_n, 1'b0);
      rchk("stat_a0", 8'h10, 8'h01);
      rtc_host_i.rd(8'h09, v);
      chk("irq0_clear", irq0_n, 1'b1);
      rtc_host_i.wr(8'h8F, 8'h00);
      hit(1'b0);
      chk("irq0_masked", irq0_n, 1'b1);
      rchk("stat_primary", 8'h10, 8'h01);
      rtc_host_i.rd(8'h8A, v);
      rchk("stat_clr", 8'h10, 8'h00);
      $display("t_alarm0 done");
   endtask
   task automatic t_alarm1;
      int n;
      rtc_host_i.wr(8'h8F, 8'h02);
      hit(1'b1);
      rchk("a1_primary", 8'h10, 8'h00);
      sup = 2'h1;
      ticks(4);
      a1m = 1'b1;
      n = 0;
      for (int k = 0; k < PCYC + 8; k++) begin
         @(negedge core_clk);
         a1m = 1'b0;
         n += irq1;
      end
      chk("pulse_len", 8'(n), 8'(PCYC));
      rchk("stat_a1", 8'h10, 8'h02);
      rtc_host_i.rd(8'h0C, v);
      rchk("stat_a1_clr", 8'h10, 8'h00);
      hit(1'b1);
      rtc_host_i.wr(8'h8F, 8'h00);
      ticks(2);
      chk("irq1_killed", irq1, 1'b0);
      rtc_host_i.rd(8'h8E, v);
      rchk("stat_wr_clr", 8'h10, 8'h00);
      sup = 2'h0;
      $display("t_alarm1 done");
   endtask
   task automatic t_battery;
      batt = 1'b1;
      sup = 2'h2;
      ticks(6);
      chk("wa_batt", wa, 1'b0);
      rtc_host_i.wr(8'h8F, 8'h04);
      chk("wref_batt", wref, 1'b1);
      rchk("ctrl_batt", 8'h0F, 8'h00);
      batt = 1'b0;
      sup = 2'h1;
      ticks(6);
      rtc_host_i.wr(8'h8F, 8'h04);
      rchk("ctrl_dual", 8'h0F, 8'h04);
      chk("wa_dual", wa, 1'b1);
      $display("t_battery done");
   endtask
   // Reset, then the scenarios in turn
   initial begin
      rst_b = 1'b0;
      {a1m, a0m} = 2'b00;
      batt = 1'b0;
      sup = 2'h0;
      ticks(5);
      rst_b = 1'b1;
      ticks(2);
      t_reset();
      t_protect();
      t_charger();
      t_alarm0();
      t_alarm1();
      t_battery();
      tally_and_finish();
   end
endmodule
`default_nettype wire
